// >>> scbt_defines.svh
// constants of the scan bus transceiver: widths, cells, opcodes, codes
`ifndef SCBT_DEFINES_SVH
`define SCBT_DEFINES_SVH

// widths of the data path and of the test registers
`define SCBT_HALF_W      9
`define SCBT_DATA_W      18
`define SCBT_IR_W        8
`define SCBT_BSR_W       48
`define SCBT_BCR_W       3
`define SCBT_ID_W        32

// boundary cell positions (lsb of each group)
`define SCBT_BSR_A_LSB   0
`define SCBT_BSR_B_LSB   18
`define SCBT_BSR_CLK_LSB 36
`define SCBT_BSR_LE_LSB  40
`define SCBT_BSR_OE_LSB  44
// enable cells reset to one so a test mode entry starts undriven
`define SCBT_BSR_RST     48'hF000_0000_0000

// instruction opcodes, all of even parity
`define SCBT_OP_EXTEST   8'h00
`define SCBT_OP_SAMPLE   8'h82
`define SCBT_OP_INTEST   8'h03
`define SCBT_OP_HIGHZ    8'h06
`define SCBT_OP_CLAMP    8'h84
`define SCBT_OP_RUNT     8'h09
`define SCBT_OP_CELLT    8'h0A
`define SCBT_OP_SCANCN   8'h87
`define SCBT_OP_IDCODE   8'h81
`define SCBT_OP_BYPASS   8'hFF
`define SCBT_IR_RST      8'h81
`define SCBT_IR_CAPTURE  8'h81

// boundary control operation codes
`define SCBT_BC_PSA      3'h2
`define SCBT_BC_PSEUDO_RANDOM_PATTERN_GEN     3'h3
`define SCBT_BC_PSACNT   3'h4
`define SCBT_BC_COUNT    3'h5
`define SCBT_BCR_RST     3'h2

// feedback tap of the 18-bit signature/pattern shifter
`define SCBT_LFSR_TAP    10
// identification value: arbitrary, lsb one as the scan standard asks
`define SCBT_IDCODE      32'h1000_0001

`endif

// >>> scbt_pkg.sv
// types of the scan bus transceiver
package scbt_pkg;
`include "scbt_defines.svh"

	// test controller states, one-hot
	typedef enum logic [15:0] {
		TAP_RESET  = 16'h0001,
		TAP_IDLE   = 16'h0002,
		TAP_SEL_DR = 16'h0004,
		TAP_CAP_DR = 16'h0008,
		TAP_SH_DR  = 16'h0010,
		TAP_EX1_DR = 16'h0020,
		TAP_PAU_DR = 16'h0040,
		TAP_EX2_DR = 16'h0080,
		TAP_UPD_DR = 16'h0100,
		TAP_SEL_IR = 16'h0200,
		TAP_CAP_IR = 16'h0400,
		TAP_SH_IR  = 16'h0800,
		TAP_EX1_IR = 16'h1000,
		TAP_PAU_IR = 16'h2000,
		TAP_EX2_IR = 16'h4000,
		TAP_UPD_IR = 16'h8000
	} scbt_tap_e;

	// control pins of one half
	typedef struct packed {
		logic a_to_b_output_enable_n;
		logic b_to_a_output_enable_n;
		logic a_to_b_latch_enable;
		logic b_to_a_latch_enable;
		logic a_to_b_clock;
		logic b_to_a_clock;
	} scbt_half_ctl_s;

	// state of one half
	typedef struct packed {
		logic [`SCBT_HALF_W-1:0] ab;
		logic [`SCBT_HALF_W-1:0] ba;
		logic                    clk_ab;
		logic                    clk_ba;
	} scbt_half_st_s;

	// state of the test controller
	typedef struct packed {
		scbt_tap_e             state;
		logic [`SCBT_IR_W-1:0] ir_sh;
		logic [`SCBT_IR_W-1:0] ir;
	} scbt_tap_st_s;

	// every input pin, as seen by a synchroniser stage
	typedef struct packed {
		logic [`SCBT_DATA_W-1:0] a;
		logic [`SCBT_DATA_W-1:0] b;
		scbt_half_ctl_s [1:0]    ctl;
		logic                    tck;
		logic                    tms;
		logic                    tdi;
	} scbt_pin_s;

	// decoded instruction
	typedef struct packed {
		logic bsr;
		logic id;
		logic bcr;
		logic test;
		logic run;
		logic highz;
	} scbt_dec_s;

	// state of the top level
	typedef struct packed {
		scbt_pin_s                s1;
		scbt_pin_s                s2;
		logic                     tck_q;
		logic [`SCBT_BSR_W-1:0]   bsr;
		logic [`SCBT_ID_W-1:0]    dr_sh;
		logic [`SCBT_BCR_W-1:0]   bcr;
		logic                     test;
		logic [`SCBT_DATA_W-1:0]  a_out;
		logic [`SCBT_DATA_W-1:0]  a_oe_n;
		logic [`SCBT_DATA_W-1:0]  b_out;
		logic [`SCBT_DATA_W-1:0]  b_oe_n;
		logic                     tdo;
		logic                     tdo_oe_n;
	} scbt_top_st_s;
endpackage

// >>> scbt_half.sv
// one 9-bit half transceiver, both directions, latch or clocked storage
`timescale 1ns/1ps
`include "scbt_defines.svh"
module scbt_half (
	input  wire logic                     clk,
	input  wire logic                     rst,
	input  wire scbt_pkg::scbt_half_ctl_s ctl,
	input  wire logic [`SCBT_HALF_W-1:0]  a_in,
	input  wire logic [`SCBT_HALF_W-1:0]  b_in,
	output logic [`SCBT_HALF_W-1:0]       b_q,
	output logic [`SCBT_HALF_W-1:0]       a_q
);
	scbt_pkg::scbt_half_st_s st_ff;  // stored data and clock history
	scbt_pkg::scbt_half_st_s nxt_st; // next state

	// storage: transparent while enabled, else load on rising clock
	always_comb begin
		nxt_st = st_ff;
		nxt_st.clk_ab = ctl.a_to_b_clock;
		nxt_st.clk_ba = ctl.b_to_a_clock;
		if (ctl.a_to_b_latch_enable) begin
			nxt_st.ab = a_in;
		end else if (ctl.a_to_b_clock && !st_ff.clk_ab) begin
			nxt_st.ab = a_in;
		end
		// other b-to-a direction mirrors a-to-b
		if (ctl.b_to_a_latch_enable) begin
			nxt_st.ba = b_in;
		end else if (ctl.b_to_a_clock && !st_ff.clk_ba) begin
			nxt_st.ba = b_in;
		end
		// no enable and no edge: value held
	end

	// state register
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign b_q = st_ff.ab;
	assign a_q = st_ff.ba;

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	AST_HALF_TRANSP: assert property (
		ctl.a_to_b_latch_enable |=> b_q == $past(a_in))
		else $error("transparent path did not follow a");
	AST_HALF_HOLD: assert property (
		(!ctl.a_to_b_latch_enable
		 && !(ctl.a_to_b_clock && !st_ff.clk_ab)) |=> $stable(b_q))
		else $error("latched b value moved");
	AST_HALF_CLOCKED: assert property (
		(!ctl.a_to_b_latch_enable && ctl.a_to_b_clock && !st_ff.clk_ab)
		|=> b_q == $past(a_in))
		else $error("rising clock did not store a");
	AST_HALF_BA: assert property (
		ctl.b_to_a_latch_enable |=> a_q == $past(b_in))
		else $error("b-to-a transparent path failed");
endmodule

// >>> scbt_tap.sv
// test controller state machine and instruction register
`timescale 1ns/1ps
`include "scbt_defines.svh"
module scbt_tap (
	input  wire logic            clk,
	input  wire logic            rst,
	input  wire logic            tck_rise,
	input  wire logic            tck_fall,
	input  wire logic            tms,
	input  wire logic            tdi,
	output scbt_pkg::scbt_tap_e  state,
	output logic [`SCBT_IR_W-1:0] ir,
	output logic                 ir_tdo
);
	scbt_pkg::scbt_tap_st_s st_ff;  // state, ir shifter, active ir
	scbt_pkg::scbt_tap_st_s nxt_st; // next value

	// advance on rising test clock per tms; ir updates on falling edge
	always_comb begin
		nxt_st = st_ff;
		if (tck_rise) begin
			case (st_ff.state)
			scbt_pkg::TAP_RESET: nxt_st.state = tms ?
				scbt_pkg::TAP_RESET : scbt_pkg::TAP_IDLE;
			scbt_pkg::TAP_IDLE: nxt_st.state = tms ?
				scbt_pkg::TAP_SEL_DR : scbt_pkg::TAP_IDLE;
			scbt_pkg::TAP_SEL_DR: nxt_st.state = tms ?
				scbt_pkg::TAP_SEL_IR : scbt_pkg::TAP_CAP_DR;
			scbt_pkg::TAP_CAP_DR, scbt_pkg::TAP_SH_DR: nxt_st.state = tms ?
				scbt_pkg::TAP_EX1_DR : scbt_pkg::TAP_SH_DR;
			scbt_pkg::TAP_EX1_DR: nxt_st.state = tms ?
				scbt_pkg::TAP_UPD_DR : scbt_pkg::TAP_PAU_DR;
			scbt_pkg::TAP_PAU_DR: nxt_st.state = tms ?
				scbt_pkg::TAP_EX2_DR : scbt_pkg::TAP_PAU_DR;
			scbt_pkg::TAP_EX2_DR: nxt_st.state = tms ?
				scbt_pkg::TAP_UPD_DR : scbt_pkg::TAP_SH_DR;
			scbt_pkg::TAP_UPD_DR, scbt_pkg::TAP_UPD_IR: nxt_st.state = tms ?
				scbt_pkg::TAP_SEL_DR : scbt_pkg::TAP_IDLE;
			scbt_pkg::TAP_SEL_IR: nxt_st.state = tms ?
				scbt_pkg::TAP_RESET : scbt_pkg::TAP_CAP_IR;
			scbt_pkg::TAP_CAP_IR, scbt_pkg::TAP_SH_IR: nxt_st.state = tms ?
				scbt_pkg::TAP_EX1_IR : scbt_pkg::TAP_SH_IR;
			scbt_pkg::TAP_EX1_IR: nxt_st.state = tms ?
				scbt_pkg::TAP_UPD_IR : scbt_pkg::TAP_PAU_IR;
			scbt_pkg::TAP_PAU_IR: nxt_st.state = tms ?
				scbt_pkg::TAP_EX2_IR : scbt_pkg::TAP_PAU_IR;
			scbt_pkg::TAP_EX2_IR: nxt_st.state = tms ?
				scbt_pkg::TAP_UPD_IR : scbt_pkg::TAP_SH_IR;
			default: nxt_st.state = scbt_pkg::TAP_RESET;
			endcase
			// capture fixed status, then shift lsb first from tdi
			if (st_ff.state == scbt_pkg::TAP_CAP_IR) begin
				nxt_st.ir_sh = `SCBT_IR_CAPTURE;
			end else if (st_ff.state == scbt_pkg::TAP_SH_IR) begin
				nxt_st.ir_sh = {tdi, st_ff.ir_sh[`SCBT_IR_W-1:1]};
			end
		end
		if (tck_fall && st_ff.state == scbt_pkg::TAP_UPD_IR) begin
			nxt_st.ir = st_ff.ir_sh;
		end
		// reset state pins the identification instruction
		if (st_ff.state == scbt_pkg::TAP_RESET) begin
			nxt_st.ir = `SCBT_IR_RST;
		end
	end

	// state register; power-up lands in the reset state
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_ff.state <= scbt_pkg::TAP_RESET;
			st_ff.ir_sh <= `SCBT_IR_CAPTURE;
			st_ff.ir    <= `SCBT_IR_RST;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign state  = st_ff.state;
	assign ir     = st_ff.ir;
	assign ir_tdo = st_ff.ir_sh[0];

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	AST_TAP_STAY_RESET: assert property (
		(st_ff.state == scbt_pkg::TAP_RESET && tck_rise && tms)
		|=> st_ff.state == scbt_pkg::TAP_RESET)
		else $error("tms high did not keep reset state");
	AST_TAP_NO_EDGE: assert property (
		!tck_rise |=> $stable(st_ff.state))
		else $error("state moved without a rising test clock");
	AST_TAP_IR_RST: assert property (
		st_ff.state == scbt_pkg::TAP_RESET |=> st_ff.ir == `SCBT_IR_RST)
		else $error("ir not loaded with identification opcode");
endmodule

// >>> scbt_xcvr.sv
// scan-testable 18-bit bus transceiver: two halves plus boundary scan
`timescale 1ns/1ps
`include "scbt_defines.svh"
// Contract
// - two independent 9-bit halves, own controls
// - latch enable high passes a to b
// - enable low, clock steady: b holds
// - enable low: rising clock stores a
// - output enable low drives b, else high-z
// - b-to-a mirrors a-to-b with own controls
// - undriven output enable reads high, outputs off
// - normal mode ignores test port activity
// - test mode: cells own every pin
// - exactly one shared boundary cell per pin
// - sample and cell self test without test mode
// - signature on inputs, random patterns on outputs
// - signature plus binary count on outputs
// - test logic samples rising, drives falling edge
// - tdi shifts into ir or register; pulled high
// - tdo shifts out ir or selected register
// - tms steers controller; pulled high
// - standard sixteen-state controller on rising test clock
// - 8-bit ir, 48/3/1/32-bit data registers
// - controller reset loads identification instruction
// - controller reset loads signature control code
module scbt_xcvr (
	input  wire logic                        clk,
	input  wire logic                        rst,
	input  wire logic [`SCBT_DATA_W-1:0]     a_in,
	output logic [`SCBT_DATA_W-1:0]          a_out,
	output logic [`SCBT_DATA_W-1:0]          a_oe_n,
	input  wire logic [`SCBT_DATA_W-1:0]     b_in,
	output logic [`SCBT_DATA_W-1:0]          b_out,
	output logic [`SCBT_DATA_W-1:0]          b_oe_n,
	input  wire scbt_pkg::scbt_half_ctl_s [1:0] half_ctl,
	input  wire logic                        tck,
	input  wire logic                        tms,
	input  wire logic                        tdi,
	output logic                             tdo,
	output logic                             tdo_oe_n
);
	scbt_pkg::scbt_top_st_s st_ff;     // all state of this level
	scbt_pkg::scbt_top_st_s nxt_st;    // next state
	scbt_pkg::scbt_tap_e    tap_state; // controller state
	scbt_pkg::scbt_dec_s    dec;       // decoded active instruction
	logic [`SCBT_IR_W-1:0]  ir;        // active instruction
	logic                   ir_tdo;    // ir shifter lsb
	logic                   tck_rise;  // one-cycle pulse per tck rise
	logic                   tck_fall;  // one-cycle pulse per tck fall
	logic [`SCBT_DATA_W-1:0] half_b;   // normal data toward b
	logic [`SCBT_DATA_W-1:0] half_a;   // normal data toward a
	logic [`SCBT_DATA_W-1:0] psa_val;  // next a-cell signature
	logic [`SCBT_DATA_W-1:0] cnt_val;  // next b-cell count

	// 18-bit shifter with one feedback tap, shared by signature/pattern
	function automatic logic [`SCBT_DATA_W-1:0] scbt_lfsr(
		input logic [`SCBT_DATA_W-1:0] v);
		scbt_lfsr = {v[`SCBT_DATA_W-2:0],
			v[`SCBT_DATA_W-1] ^ v[`SCBT_LFSR_TAP]};
	endfunction

	// instruction decode; unknown opcodes act as bypass
	function automatic scbt_pkg::scbt_dec_s scbt_decode(
		input logic [`SCBT_IR_W-1:0] op);
		scbt_decode = '0;
		case (op)
		`SCBT_OP_EXTEST, `SCBT_OP_INTEST: begin
			scbt_decode.bsr  = 1'b1;
			scbt_decode.test = 1'b1;
		end
		`SCBT_OP_SAMPLE: begin
			scbt_decode.bsr = 1'b1;
		end
		`SCBT_OP_RUNT: begin
			scbt_decode.bsr  = 1'b1;
			scbt_decode.test = 1'b1;
			scbt_decode.run  = 1'b1;
		end
		`SCBT_OP_CELLT: begin
			// cell self test runs while pins stay normal
			scbt_decode.bsr = 1'b1;
			scbt_decode.run = 1'b1;
		end
		`SCBT_OP_HIGHZ: begin
			scbt_decode.test  = 1'b1;
			scbt_decode.highz = 1'b1;
		end
		`SCBT_OP_CLAMP: begin
			scbt_decode.test = 1'b1;
		end
		`SCBT_OP_IDCODE: begin
			scbt_decode.id = 1'b1;
		end
		`SCBT_OP_SCANCN: begin
			scbt_decode.bcr = 1'b1;
		end
		default: begin
			scbt_decode = '0;
		end
		endcase
	endfunction

	// test port edges, found on synchronised tck only
	assign tck_rise = st_ff.s2.tck & ~st_ff.tck_q;
	assign tck_fall = ~st_ff.s2.tck & st_ff.tck_q;
	assign dec      = scbt_decode(ir);

	// test operation results, also read by the checks below
	assign psa_val = scbt_lfsr(st_ff.bsr[`SCBT_BSR_A_LSB +: `SCBT_DATA_W])
		^ st_ff.s2.a;
	assign cnt_val = st_ff.bsr[`SCBT_BSR_B_LSB +: `SCBT_DATA_W]
		+ `SCBT_DATA_W'(1);

	// controller and instruction register
	scbt_tap u_tap (
		.clk      (clk),
		.rst      (rst),
		.tck_rise (tck_rise),
		.tck_fall (tck_fall),
		.tms      (st_ff.s2.tms),
		.tdi      (st_ff.s2.tdi),
		.state    (tap_state),
		.ir       (ir),
		.ir_tdo   (ir_tdo)
	);

	// two halves, each on its own controls
	genvar h;
	generate
		for (h = 0; h < 2; h = h + 1) begin : g_half
			scbt_half u_half (
				.clk  (clk),
				.rst  (rst),
				.ctl  (st_ff.s2.ctl[h]),
				.a_in (st_ff.s2.a[h*`SCBT_HALF_W +: `SCBT_HALF_W]),
				.b_in (st_ff.s2.b[h*`SCBT_HALF_W +: `SCBT_HALF_W]),
				.b_q  (half_b[h*`SCBT_HALF_W +: `SCBT_HALF_W]),
				.a_q  (half_a[h*`SCBT_HALF_W +: `SCBT_HALF_W])
			);
		end
	endgenerate

	// next state: sync, test registers, tdo, pin drivers
	always_comb begin
		nxt_st = st_ff;
		// two-stage synchroniser on every pin input
		nxt_st.s1.a   = a_in;
		nxt_st.s1.b   = b_in;
		nxt_st.s1.ctl = half_ctl;
		nxt_st.s1.tck = tck;
		nxt_st.s1.tms = tms;
		nxt_st.s1.tdi = tdi;
		nxt_st.s2     = st_ff.s1;
		nxt_st.tck_q  = st_ff.s2.tck;

		if (tap_state == scbt_pkg::TAP_RESET) begin
			// controller reset: benign enable cells, signature code
			nxt_st.bcr = `SCBT_BCR_RST;
			nxt_st.bsr[`SCBT_BSR_OE_LSB +: 4] = 4'hF;
		end else if (tck_rise) begin
			case (tap_state)
			scbt_pkg::TAP_CAP_DR: begin
				if (dec.bsr) begin
					// one cell per pin catches the pin level
					nxt_st.bsr[`SCBT_BSR_A_LSB +: `SCBT_DATA_W] = st_ff.s2.a;
					nxt_st.bsr[`SCBT_BSR_B_LSB +: `SCBT_DATA_W] = st_ff.s2.b;
					for (int i = 0; i < 2; i++) begin
						nxt_st.bsr[`SCBT_BSR_OE_LSB + 2*i] =
							st_ff.s2.ctl[i].a_to_b_output_enable_n;
						nxt_st.bsr[`SCBT_BSR_OE_LSB + 2*i + 1] =
							st_ff.s2.ctl[i].b_to_a_output_enable_n;
						nxt_st.bsr[`SCBT_BSR_LE_LSB + 2*i] =
							st_ff.s2.ctl[i].a_to_b_latch_enable;
						nxt_st.bsr[`SCBT_BSR_LE_LSB + 2*i + 1] =
							st_ff.s2.ctl[i].b_to_a_latch_enable;
						nxt_st.bsr[`SCBT_BSR_CLK_LSB + 2*i] =
							st_ff.s2.ctl[i].a_to_b_clock;
						nxt_st.bsr[`SCBT_BSR_CLK_LSB + 2*i + 1] =
							st_ff.s2.ctl[i].b_to_a_clock;
					end
				end else if (dec.id) begin
					nxt_st.dr_sh = `SCBT_IDCODE;
				end else if (dec.bcr) begin
					nxt_st.dr_sh = {29'h0, st_ff.bcr};
				end else begin
					nxt_st.dr_sh = '0;
				end
			end
			scbt_pkg::TAP_SH_DR: begin
				// serial path length follows the selected register
				if (dec.bsr) begin
					nxt_st.bsr = {st_ff.s2.tdi, st_ff.bsr[`SCBT_BSR_W-1:1]};
				end else if (dec.id) begin
					nxt_st.dr_sh = {st_ff.s2.tdi, st_ff.dr_sh[`SCBT_ID_W-1:1]};
				end else if (dec.bcr) begin
					nxt_st.dr_sh[2:0] = {st_ff.s2.tdi, st_ff.dr_sh[2:1]};
				end else begin
					nxt_st.dr_sh[0] = st_ff.s2.tdi;
				end
			end
			scbt_pkg::TAP_IDLE: begin
				// boundary operations step once per test clock in idle
				if (dec.run) begin
					case (st_ff.bcr)
					`SCBT_BC_PSA: begin
						nxt_st.bsr[`SCBT_BSR_A_LSB +: `SCBT_DATA_W] =
							psa_val;
					end
					`SCBT_BC_PSEUDO_RANDOM_PATTERN_GEN: begin
						nxt_st.bsr[`SCBT_BSR_B_LSB +: `SCBT_DATA_W] = scbt_lfsr(
							st_ff.bsr[`SCBT_BSR_B_LSB +: `SCBT_DATA_W]);
					end
					`SCBT_BC_PSACNT: begin
						nxt_st.bsr[`SCBT_BSR_A_LSB +: `SCBT_DATA_W] = psa_val;
						nxt_st.bsr[`SCBT_BSR_B_LSB +: `SCBT_DATA_W] =
							cnt_val;
					end
					`SCBT_BC_COUNT: begin
						nxt_st.bsr[`SCBT_BSR_B_LSB +: `SCBT_DATA_W] = cnt_val;
					end
					default: begin
						// other codes leave the cells alone
						nxt_st.bsr = st_ff.bsr;
					end
					endcase
				end
			end
			default: begin
				// no register action in the remaining states
				nxt_st.bsr = st_ff.bsr;
			end
			endcase
		end

		if (tck_fall) begin
			if (tap_state == scbt_pkg::TAP_UPD_DR && dec.bcr) begin
				nxt_st.bcr = st_ff.dr_sh[2:0];
			end
			// tdo drives only while a shift state holds
			if (tap_state == scbt_pkg::TAP_SH_DR) begin
				nxt_st.tdo      = dec.bsr ? st_ff.bsr[0] : st_ff.dr_sh[0];
				nxt_st.tdo_oe_n = 1'b0;
			end else if (tap_state == scbt_pkg::TAP_SH_IR) begin
				nxt_st.tdo      = ir_tdo;
				nxt_st.tdo_oe_n = 1'b0;
			end else begin
				nxt_st.tdo_oe_n = 1'b1;
			end
			// mode follows instruction, reset state forces normal
			nxt_st.test = dec.test
				&& tap_state != scbt_pkg::TAP_RESET;
		end

		if (nxt_st.test) begin
			// test mode: cells drive pins, changed on falling tck only
			if (tck_fall) begin
				nxt_st.a_out = st_ff.bsr[`SCBT_BSR_A_LSB +: `SCBT_DATA_W];
				nxt_st.b_out = st_ff.bsr[`SCBT_BSR_B_LSB +: `SCBT_DATA_W];
				for (int i = 0; i < 2; i++) begin
					nxt_st.b_oe_n[i*`SCBT_HALF_W +: `SCBT_HALF_W] =
						{`SCBT_HALF_W{dec.highz
						| st_ff.bsr[`SCBT_BSR_OE_LSB + 2*i]}};
					nxt_st.a_oe_n[i*`SCBT_HALF_W +: `SCBT_HALF_W] =
						{`SCBT_HALF_W{dec.highz
						| st_ff.bsr[`SCBT_BSR_OE_LSB + 2*i + 1]}};
				end
			end
		end else begin
			// normal mode: test port has no say over the pins
			nxt_st.a_out = half_a;
			nxt_st.b_out = half_b;
			for (int i = 0; i < 2; i++) begin
				// a floating enable pulls high and so stays off
				nxt_st.b_oe_n[i*`SCBT_HALF_W +: `SCBT_HALF_W] =
					{`SCBT_HALF_W{st_ff.s2.ctl[i].a_to_b_output_enable_n}};
				nxt_st.a_oe_n[i*`SCBT_HALF_W +: `SCBT_HALF_W] =
					{`SCBT_HALF_W{st_ff.s2.ctl[i].b_to_a_output_enable_n}};
			end
		end
	end

	// state register; power-up leaves every driver off
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_ff          <= '0;
			// sync stages start at the pulled-up idle level of the control
			// pins, else the enables would read low and drive for two cycles
			st_ff.s1.ctl   <= '1;
			st_ff.s2.ctl   <= '1;
			st_ff.bsr      <= `SCBT_BSR_RST;
			st_ff.bcr      <= `SCBT_BCR_RST;
			st_ff.a_oe_n   <= '1;
			st_ff.b_oe_n   <= '1;
			st_ff.tdo_oe_n <= 1'b1;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign a_out    = st_ff.a_out;
	assign a_oe_n   = st_ff.a_oe_n;
	assign b_out    = st_ff.b_out;
	assign b_oe_n   = st_ff.b_oe_n;
	assign tdo      = st_ff.tdo;
	assign tdo_oe_n = st_ff.tdo_oe_n;

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	AST_OE_OFF: assert property (
		(!st_ff.test && !tck_fall
		 && st_ff.s2.ctl[0].a_to_b_output_enable_n)
		|=> b_oe_n[`SCBT_HALF_W-1:0] == 9'h1FF)
		else $error("b outputs driven with enable high");
	AST_NORMAL_PASS: assert property (
		(!st_ff.test && !tck_fall) |=> b_out == $past(half_b))
		else $error("normal b data disturbed");
	AST_TEST_HOLD: assert property (
		(st_ff.test && !tck_fall) |=> ($stable(b_out) && $stable(a_oe_n)))
		else $error("test outputs moved off the falling edge");
	AST_TEST_DRIVE: assert property (
		(nxt_st.test && tck_fall)
		|=> b_out == $past(st_ff.bsr[`SCBT_BSR_B_LSB +: `SCBT_DATA_W]))
		else $error("test mode b pins not from cells");
	AST_PSA: assert property (
		(tck_rise && tap_state == scbt_pkg::TAP_IDLE && dec.run
		 && st_ff.bcr == `SCBT_BC_PSA)
		|=> st_ff.bsr[`SCBT_BSR_A_LSB +: `SCBT_DATA_W] == $past(psa_val))
		else $error("signature step wrong");
	AST_COUNT: assert property (
		(tck_rise && tap_state == scbt_pkg::TAP_IDLE && dec.run
		 && st_ff.bcr == `SCBT_BC_PSACNT)
		|=> st_ff.bsr[`SCBT_BSR_B_LSB +: `SCBT_DATA_W] == $past(cnt_val))
		else $error("count step wrong");
	AST_BCR_RST: assert property (
		tap_state == scbt_pkg::TAP_RESET |=> st_ff.bcr == `SCBT_BCR_RST)
		else $error("control register not reset");
	AST_TDO_SHIFT: assert property (
		(tck_fall && tap_state == scbt_pkg::TAP_SH_DR && dec.bsr)
		|=> (tdo == $past(st_ff.bsr[0]) && !tdo_oe_n))
		else $error("tdo not boundary lsb");
	AST_RESET_NORMAL: assert property (
		(tap_state == scbt_pkg::TAP_RESET && tck_fall) |=> !st_ff.test)
		else $error("test mode kept in controller reset");
endmodule

// >>> scbt_bus_model.sv
// bus logic on the A and B sides, sharing each wire with the dut
`timescale 1ns/1ps
`include "scbt_defines.svh"
module scbt_bus_model (
	input  wire logic [`SCBT_DATA_W-1:0] a_drv,
	input  wire logic [`SCBT_DATA_W-1:0] b_drv,
	input  wire logic [`SCBT_DATA_W-1:0] a_out,
	input  wire logic [`SCBT_DATA_W-1:0] a_oe_n,
	input  wire logic [`SCBT_DATA_W-1:0] b_out,
	input  wire logic [`SCBT_DATA_W-1:0] b_oe_n,
	output logic      [`SCBT_DATA_W-1:0] a_in,
	output logic      [`SCBT_DATA_W-1:0] b_in
);
	// wire level per bit: the dut wins where enabled, else the far side
	always_comb begin
		a_in = (a_drv & a_oe_n) | (a_out & ~a_oe_n);
		b_in = (b_drv & b_oe_n) | (b_out & ~b_oe_n);
	end
endmodule

// >>> scbt_xcvr_tb.sv
// self-checking bench: data paths, id readout, test mode entry and exit
`timescale 1ns/1ps
`include "scbt_defines.svh"
module scbt_xcvr_tb;
	logic                            clk = 1'b0;
	logic                            rst = 1'b1;
	logic [`SCBT_DATA_W-1:0]         a_drv = '0, b_drv = '0, s, s2;
	logic [`SCBT_DATA_W-1:0]         a_in, b_in, a_out, b_out;
	logic [`SCBT_DATA_W-1:0]         a_oe_n, b_oe_n;
	scbt_pkg::scbt_half_ctl_s [1:0]  ctl = '1; // enables idle high
	logic                            tck = 1'b0, tms = 1'b1, tdi = 1'b1;
	logic                            tdo, tdo_oe_n;
	logic [31:0]                     q;
	int                              errors = 0, checks = 0, cyc = 0;

	always #5 clk = ~clk;

	scbt_xcvr dut (.clk(clk), .rst(rst), .a_in(a_in), .a_out(a_out),
		.a_oe_n(a_oe_n), .b_in(b_in), .b_out(b_out), .b_oe_n(b_oe_n),
		.half_ctl(ctl), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
		.tdo_oe_n(tdo_oe_n));
	scbt_bus_model bus (.a_drv(a_drv), .b_drv(b_drv), .a_out(a_out),
		.a_oe_n(a_oe_n), .b_out(b_out), .b_oe_n(b_oe_n), .a_in(a_in),
		.b_in(b_in));

	task chk(input logic [47:0] seen, input logic [47:0] exp);
		checks++;
		if (seen !== exp) begin
			errors++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task final_report;
		$display("checks=%0d errors=%0d", checks, errors);
		if (errors == 0 && checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask

	// cuts a hang short; a full run needs a few thousand cycles
	always @(posedge clk) begin
		cyc++;
		if (cyc > 20000) begin
			errors++;
			final_report;
		end
	end

	// controls of one direction: d=1 is b to a, the other side kept off
	function automatic logic [5:0] mk(input bit d, input logic oe,
		input logic le, input logic ck);
		return d ? {1'b1, oe, 1'b0, le, 1'b0, ck}
			: {oe, 1'b1, le, 1'b0, ck, 1'b0};
	endfunction

	// same controls on both halves, then let the sync latency pass
	task setc(input logic [5:0] c);
		@(posedge clk) ctl <= {c, c};
		repeat (8) @(posedge clk);
	endtask

	task drv(input bit d, input logic [`SCBT_DATA_W-1:0] v);
		@(posedge clk);
		if (d) b_drv <= v;
		else a_drv <= v;
	endtask

	// one direction through transparent, held, clocked and off
	task flow(input bit d);
		s = 18'($urandom);
		s2 = 18'($urandom);
		drv(d, s);
		setc(mk(d, 1'b0, 1'b1, 1'b0));
		chk(d ? a_out : b_out, s);
		chk(d ? a_oe_n : b_oe_n, 18'h0);
		setc(mk(d, 1'b0, 1'b0, 1'b0));
		drv(d, s2);
		repeat (8) @(posedge clk);
		chk(d ? a_out : b_out, s);
		setc(mk(d, 1'b0, 1'b0, 1'b1));
		chk(d ? a_out : b_out, s2);
		drv(d, ~s2); // falling clock edge must not store
		setc(mk(d, 1'b0, 1'b0, 1'b0));
		chk(d ? a_out : b_out, s2);
		setc(mk(d, 1'b1, 1'b0, 1'b0));
		chk(d ? a_oe_n : b_oe_n, 18'h3FFFF);
	endtask

	// one test clock period; tms and tdi settle before the rise
	task tk(input logic m, input logic d);
		@(posedge clk);
		tms <= m;
		tdi <= d;
		repeat (3) @(posedge clk);
		tck <= 1'b1;
		repeat (6) @(posedge clk);
		tck <= 1'b0;
		repeat (6) @(posedge clk);
	endtask

	// shift n bits lsb first from a shift state, update, park in idle
	task sh(input int n, input logic [31:0] d);
		q = '0;
		chk(tdo_oe_n, 1'b0);
		for (int i = 0; i < n; i++) begin
			q[i] = tdo;
			tk(i == n - 1, d[i]);
		end
		tk(1'b1, 1'b1);
		tk(1'b0, 1'b1);
	endtask

	// instruction scan from idle, back in idle afterwards
	task ir(input logic [7:0] op);
		tk(1, 1);
		tk(1, 1);
		tk(0, 1);
		tk(0, 1);
		sh(8, {24'h0, op});
	endtask

	// data scan of n bits from idle: select, capture, shift, update
	task dr(input int n, input logic [31:0] d);
		tk(1, 1);
		tk(0, 1);
		tk(0, 1);
		sh(n, d);
	endtask

	initial begin
		void'($urandom(84));
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		// look while the synchronisers still fill after reset
		repeat (2) @(posedge clk);
		chk({a_oe_n, b_oe_n}, 36'hF_FFFF_FFFF);
		chk(tdo_oe_n, 1'b1);
		for (int k = 0; k < 6; k++) flow(k[0]);
		// halves apart: only half 0 drives b
		@(posedge clk) ctl <= {mk(0, 1'b1, 1'b1, 1'b0), mk(0, 1'b0, 1'b1, 1'b0)};
		repeat (8) @(posedge clk);
		chk(b_oe_n, 18'h3FE00);
		// id readout while data keeps flowing a to b
		drv(0, s);
		setc(mk(0, 1'b0, 1'b1, 1'b0));
		tk(0, 1);
		dr(32, 32'h0);
		chk(q, `SCBT_IDCODE);
		chk(b_out, s);
		// load the high-z instruction, then reset by tms held high
		ir(`SCBT_OP_HIGHZ);
		chk(q[7:0], `SCBT_IR_CAPTURE);
		tk(0, 1);
		repeat (8) @(posedge clk);
		chk(b_oe_n, 18'h3FFFF);
		repeat (6) tk(1, 1);
		repeat (8) @(posedge clk);
		chk(b_oe_n, 18'h0);
		// cell self test in normal mode: signature steps in idle
		tk(0, 1);
		ir(`SCBT_OP_CELLT);
		repeat (3) tk(0, 1);
		// capture catches a and b pins, one cell each, lsb first
		dr(32, 32'h0);
		chk(q, {s[13:0], s});
		// control register reads its reset code, then takes signature plus count mode
		ir(`SCBT_OP_SCANCN);
		dr(3, {29'h0, `SCBT_BC_PSACNT});
		chk(q[2:0], `SCBT_BCR_RST);
		ir(`SCBT_OP_CELLT);
		repeat (3) tk(0, 1);
		chk(b_out, s);
		final_report;
	end
endmodule
